//--- logic/stc_counter_unit.sv
// Counter unit of the 16-bit timer with its AHB-Lite register slave.
// Assumes the bus clock is CLK_I and that the external tick pin is asynchronous.
`timescale 1ns/10ps

module stc_counter_unit
    import stc_pkg::*;
(
    input wire logic CLK_I, // System clock, 10 MHz
    input wire logic RSTN_I, // Synchronous reset, active low
    input wire logic HSEL_I, // Slave select
    input wire logic [31:0] HADDR_I, // Byte address
    input wire logic [1:0] HTRANS_I, // Transfer type
    input wire logic HWRITE_I, // Write when high
    input wire logic [2:0] HSIZE_I, // Transfer size, word only
    input wire logic [31:0] HWDATA_I, // Write data
    input wire logic HREADY_I, // Bus ready
    output logic [31:0] HRDATA_O, // Read data
    output logic HREADYOUT_O, // Slave ready
    output logic HRESP_O, // Always OKAY
    input wire logic EXT_TICK_I, // External tick pin
    output logic [1:0] COMPARE_OUTPUT_PIN_O, // Compare outputs, bit 0 is A
    output logic OVERFLOW_FLAG_O, // Overflow flag
    output logic COUNT_AT_TOP_O, // Counter equals current top
    output logic COUNT_AT_BOTTOM_O, // Counter equals zero
    output logic COUNT_DOWN_O // Direction select, high counts down
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
                                           input logic [15:0] c);
        unique case (m)
            4'h1, 4'h5: top_of = TOP_8BIT;
            4'h2, 4'h6: top_of = TOP_9BIT;
            4'h3, 4'h7: top_of = TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
            4'h8, 4'hA, 4'hC, 4'hE: top_of = c;
            default: top_of = CNT_MAX;
        endcase
    endfunction

    function automatic logic pin_act(input logic [1:0] com, input logic pin);
        unique case (com)
            2'h1: pin_act = !pin;
            2'h2: pin_act = 1'b0;
            2'h3: pin_act = 1'b1;
            default: pin_act = pin;
        endcase
    endfunction

    function automatic logic pre_hit(input logic [9:0] cnt, input logic [9:0] mask);
        pre_hit = (cnt & mask) == mask;
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    stc_bus_e bus_reg, bus_next;
    logic [7:0] addr_reg, addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic accept, wr_en, rd_cap, cnt_wr;

    assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign wr_en = bus_reg == BUS_WRITE;
    assign rd_cap = bus_reg == BUS_RDWAIT;
    assign cnt_wr = wr_en && addr_reg == OFS_CNT_LOW;
    assign HREADYOUT_O = bus_reg != BUS_RDWAIT;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_reg;

    always_comb begin
        bus_next = BUS_IDLE;
        addr_next = addr_reg;
        if (accept) begin
            bus_next = HWRITE_I ? BUS_WRITE : BUS_RDWAIT;
            addr_next = HADDR_I[7:0];
        end else if (bus_reg == BUS_RDWAIT) begin
            bus_next = BUS_RDDONE;
        end
    end

    // ----------------------------------------------------------------
    // Tick source
    // ----------------------------------------------------------------
    stc_cfg_s cfg_reg, cfg_next;
    logic [9:0] pre_reg, pre_next;
    logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
    logic tick;

    always_comb begin
        pre_next = (cfg_reg.cs == CS_STOP) ? 10'h000 : pre_reg + 10'h001;
        unique case (cfg_reg.cs)
            CS_DIV1: tick = 1'b1;
            3'h2: tick = pre_hit(pre_reg, PRE_MASK_8);
            3'h3: tick = pre_hit(pre_reg, PRE_MASK_64);
            3'h4: tick = pre_hit(pre_reg, PRE_MASK_256);
            3'h5: tick = pre_hit(pre_reg, PRE_MASK_1024);
            3'h6: tick = !ext_s2_reg && ext_s3_reg;
            3'h7: tick = ext_s2_reg && !ext_s3_reg;
            default: tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    logic [15:0] cnt_reg, cnt_next;
    logic [7:0] temp_reg, temp_next;
    logic down_reg, down_next;
    logic [1:0][15:0] cmp_reg, cmp_next;
    logic [15:0] cap_reg, cap_next;
    logic [15:0] top;
    logic dual, fast, pwm, at_top, at_bottom, ovf_evt;
    logic [15:0] wr_value;
    logic [7:0] cnt_hi;

    assign top = top_of(cfg_reg.wgm, cmp_reg[0], cap_reg);
    assign dual = cfg_reg.wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
    assign fast = cfg_reg.wgm inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
    assign pwm = dual || fast;
    assign at_top = cnt_reg == top;
    assign at_bottom = cnt_reg == 16'h0000;
    assign wr_value = {temp_reg, HWDATA_I[7:0]};
    assign cnt_hi = cnt_reg[15:8];

    always_comb begin
        cnt_next = cnt_reg;
        down_next = down_reg;
        ovf_evt = 1'b0;
        if (cnt_wr) begin
            cnt_next = wr_value;
        end else if (tick) begin
            if (dual) begin
                if (!down_reg && cnt_reg >= top) begin
                    down_next = 1'b1;
                    cnt_next = cnt_reg - 16'h0001;
                end else if (down_reg && at_bottom) begin
                    down_next = 1'b0;
                    cnt_next = cnt_reg + 16'h0001;
                end else begin
                    cnt_next = down_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
                end
                ovf_evt = down_reg && at_bottom;
            end else begin
                down_next = 1'b0;
                // Wraps from MAX to zero in normal mode
                cnt_next = at_top ? 16'h0000 : cnt_reg + 16'h0001;
                ovf_evt = fast ? at_top : cnt_reg == CNT_MAX;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers written and read by software
    // ----------------------------------------------------------------
    logic [2:0] flg_reg, flg_next;
    logic [1:0] force_req, match;

    always_comb begin
        cfg_next = cfg_reg;
        temp_next = temp_reg;
        cmp_next = cmp_reg;
        cap_next = cap_reg;
        force_req = 2'b00;
        rdata_next = rdata_reg;
        if (wr_en) begin
            unique case (addr_reg)
                OFS_CTRL_A: begin
                    cfg_next.wgm[1:0] = HWDATA_I[CA_WGM_LO +: 2];
                    cfg_next.com[1] = HWDATA_I[CA_COM_B +: 2];
                    cfg_next.com[0] = HWDATA_I[CA_COM_A +: 2];
                end
                OFS_CTRL_B: begin
                    cfg_next.cs = HWDATA_I[CB_CS +: 3];
                    cfg_next.wgm[3:2] = HWDATA_I[CB_WGM_HI +: 2];
                end
                OFS_FORCE: force_req = {HWDATA_I[FRC_B], HWDATA_I[FRC_A]};
                OFS_CNT_HIGH: temp_next = HWDATA_I[7:0];
                OFS_CMP_A: cmp_next[0] = HWDATA_I[15:0];
                OFS_CMP_B: cmp_next[1] = HWDATA_I[15:0];
                OFS_CAPTURE: cap_next = HWDATA_I[15:0];
                default: ;
            endcase
        end
        if (rd_cap) begin
            rdata_next = 32'h0000_0000;
            unique case (addr_reg)
                OFS_CTRL_A: rdata_next[7:0] = {cfg_reg.com[0], cfg_reg.com[1], 2'b00,
                                               cfg_reg.wgm[1:0]};
                OFS_CTRL_B: rdata_next[4:0] = {cfg_reg.wgm[3:2], cfg_reg.cs};
                OFS_CNT_LOW: begin
                    rdata_next[7:0] = cnt_reg[7:0];
                    temp_next = cnt_hi;
                end
                OFS_CNT_HIGH: rdata_next[7:0] = temp_reg;
                OFS_CMP_A: rdata_next[15:0] = cmp_reg[0];
                OFS_CMP_B: rdata_next[15:0] = cmp_reg[1];
                OFS_CAPTURE: rdata_next[15:0] = cap_reg;
                OFS_FLAGS: rdata_next[2:0] = flg_reg;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Flags and compare outputs
    // ----------------------------------------------------------------
    logic [1:0] pin_reg, pin_next;
    logic [1:0][1:0] com_act_reg, com_act_next;
    logic pin_a;

    assign pin_a = pin_reg[0];

    always_comb begin
        flg_next = flg_reg;
        pin_next = pin_reg;
        com_act_next = com_act_reg;
        if (wr_en && addr_reg == OFS_FLAGS) begin
            flg_next = flg_reg & ~HWDATA_I[2:0];
        end
        for (int i = 0; i < 2; i++) begin
            match[i] = tick && cnt_reg == cmp_reg[i];
            if ((force_req[i] && !pwm) || match[i]) begin
                com_act_next[i] = cfg_reg.com[i];
            end
            if (force_req[i] && !pwm) begin
                pin_next[i] = pin_act(cfg_reg.com[i], pin_reg[i]);
            end else if (match[i]) begin
                if (!pwm) begin
                    pin_next[i] = pin_act(cfg_reg.com[i], pin_reg[i]);
                end else if (cfg_reg.com[i][1]) begin
                    pin_next[i] = cfg_reg.com[i][0] ^ (dual && down_reg);
                end
            end else if (fast && tick && at_top && com_act_reg[i][1]) begin
                pin_next[i] = !com_act_reg[i][0];
            end
        end
        // Hardware set wins over a software clear
        flg_next[FLG_OVF] = flg_next[FLG_OVF] | ovf_evt;
        flg_next[FLG_MATCH_A] = flg_next[FLG_MATCH_A] | match[0];
        flg_next[FLG_MATCH_B] = flg_next[FLG_MATCH_B] | match[1];
    end

    assign COMPARE_OUTPUT_PIN_O = pin_reg;
    assign OVERFLOW_FLAG_O = flg_reg[FLG_OVF];
    assign COUNT_AT_TOP_O = at_top;
    assign COUNT_AT_BOTTOM_O = at_bottom;
    assign COUNT_DOWN_O = down_reg;

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        ext_s1_reg <= EXT_TICK_I;
        ext_s2_reg <= ext_s1_reg;
        if (!RSTN_I) begin
            bus_reg <= BUS_IDLE;
            addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            cfg_reg <= '0;
            pre_reg <= 10'h000;
            ext_s3_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            temp_reg <= 8'h00;
            down_reg <= 1'b0;
            cmp_reg <= '0;
            cap_reg <= 16'h0000;
            flg_reg <= 3'h0;
            pin_reg <= 2'b00;
            com_act_reg <= '0;
        end else begin
            bus_reg <= bus_next;
            addr_reg <= addr_next;
            rdata_reg <= rdata_next;
            cfg_reg <= cfg_next;
            pre_reg <= pre_next;
            ext_s3_reg <= ext_s2_reg;
            cnt_reg <= cnt_next;
            temp_reg <= temp_next;
            down_reg <= down_next;
            cmp_reg <= cmp_next;
            cap_reg <= cap_next;
            flg_reg <= flg_next;
            pin_reg <= pin_next;
            com_act_reg <= com_act_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    property p_stopped;
        (cfg_reg.cs == CS_STOP && !cnt_wr) |=> $stable(cnt_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("Counter moved while stopped");

    property p_step;
        (tick && cfg_reg.wgm == WGM_NORMAL && !cnt_wr) |=> cnt_reg == $past(cnt_reg) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("Normal count did not step by one");

    property p_ctc_clear;
        (tick && cfg_reg.wgm == WGM_CTC_CMP && cnt_reg == cmp_reg[0] && !cnt_wr)
            |=> cnt_reg == 16'h0000;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("No clear at compare A");

    property p_ovf;
        (tick && cfg_reg.wgm == WGM_NORMAL && cnt_reg == CNT_MAX && !cnt_wr)
            |=> OVERFLOW_FLAG_O && cnt_reg == 16'h0000;
    endproperty
    a_ovf: assert property (p_ovf) else $error("Overflow flag not set on wrap");

    property p_temp_read;
        (rd_cap && addr_reg == OFS_CNT_LOW) |=> temp_reg == $past(cnt_hi) ##1 temp_reg == $past(cnt_hi, 2);
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("High byte not latched");

    property p_low_write;
        cnt_wr |=> cnt_reg == $past(wr_value);
    endproperty
    a_low_write: assert property (p_low_write) else $error("Counter write lost");

    property p_tick_src;
        (tick |-> cfg_reg.cs != CS_STOP) and (cfg_reg.cs == CS_DIV1 |-> tick);
    endproperty
    a_tick_src: assert property (p_tick_src) else $error("Tick disagrees with source");

    property p_force;
        (force_req[0] && !pwm && cfg_reg.com[0] == 2'h1) |=> pin_a != $past(pin_a);
    endproperty
    a_force: assert property (p_force) else $error("Force did not toggle output");

    property p_turn;
        (tick && dual && !down_reg && cnt_reg >= top && !cnt_wr)
            |=> down_reg && cnt_reg == $past(cnt_reg) - 16'h0001;
    endproperty
    a_turn: assert property (p_turn) else $error("No turn at top");

    property p_read_wait;
        rd_cap |-> !HREADYOUT_O ##1 HREADYOUT_O;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("Read wait wrong length");

endmodule // stc_counter_unit

//--- shared/stc_pkg.sv
// Constants, types and register map of the 16-bit timer counter unit.
// Assumes one system clock; the processor reaches it over AHB-Lite.
//
// Operation
// - Sixteen-bit counter counts up or down under an internal direction select.
// - A count step changes the counter by exactly one in the selected direction.
// - A clear forces every counter bit to zero.
// - Top indication at the current maximum, bottom indication at zero.
// - Counter is seen as two 8-bit locations, high byte and low byte.
// - High-byte accesses reach a shared temporary byte, not the counter.
// - Reading the low byte copies the counter high byte into the temporary byte.
// - Writing the low byte loads the high byte from the temporary byte at once.
// - Counter is cleared, incremented or decremented only on timer ticks.
// - A three-bit tick source select picks internal or external ticks.
// - Tick source select of zero stops the counter.
// - Software may read and write the counter whether ticks run or not.
// - A software counter write beats a clear or count in the same cycle.
// - A four-bit waveform mode, split over two control registers, picks the sequence.
// - A new compare output mode acts from the next compare match only.
// - In non-PWM modes the force strobe applies the compare action at once.
// - Normal mode counts up without clearing, wrapping from 0xFFFF to zero.
// - Normal mode sets the overflow flag on the tick the counter becomes zero.
// - Clear-on-compare mode clears at compare value A (mode 4) or capture (12).

package stc_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_FORCE = 8'h08;
    localparam logic [7:0] OFS_CNT_LOW = 8'h0C;
    localparam logic [7:0] OFS_CNT_HIGH = 8'h10;
    localparam logic [7:0] OFS_CMP_A = 8'h14;
    localparam logic [7:0] OFS_CMP_B = 8'h18;
    localparam logic [7:0] OFS_CAPTURE = 8'h1C;
    localparam logic [7:0] OFS_FLAGS = 8'h20;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned CA_WGM_LO = 0;
    localparam int unsigned CA_COM_B = 4;
    localparam int unsigned CA_COM_A = 6;
    localparam int unsigned CB_CS = 0;
    localparam int unsigned CB_WGM_HI = 3;
    localparam int unsigned FRC_B = 6;
    localparam int unsigned FRC_A = 7;
    localparam int unsigned FLG_OVF = 0;
    localparam int unsigned FLG_MATCH_A = 1;
    localparam int unsigned FLG_MATCH_B = 2;

    // ----------------------------------------------------------------
    // Values
    // ----------------------------------------------------------------
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CTC_CMP = 4'h4;
    localparam logic [3:0] WGM_CTC_CAP = 4'hC;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    // Prescaler masks for divide by 8, 64, 256 and 1024
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_64 = 10'h03F;
    localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

    typedef struct packed {
        logic [3:0] wgm;
        logic [2:0] cs;
        logic [1:0][1:0] com;
    } stc_cfg_s;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_RDWAIT = 4'b0100,
        BUS_RDDONE = 4'b1000
    } stc_bus_e;

endpackage

//--- sim/stc_bus_master.sv
// AHB-Lite master standing in for the processor core, single word transfers.
// Assumes one slave whose ready output is looped back as the bus ready.
`timescale 1ns/10ps

module stc_bus_master (
    input wire logic clk_i, // System clock
    input wire logic hready_i, // Bus ready
    input wire logic [31:0] hrdata_i, // Read data
    output logic hsel_o, // Slave select
    output logic [31:0] haddr_o, // Byte address
    output logic [1:0] htrans_o, // Transfer type
    output logic hwrite_o, // Write when high
    output logic [2:0] hsize_o, // Transfer size, word
    output logic [31:0] hwdata_o // Write data
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'h0;
        hwdata_o = 32'hA5A5A5A5;
    end

    // ----------------------------------------------------------------
    // Single transfer
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, ofs};
        htrans_o <= 2'b10;
        hwrite_o <= wr;
        hsize_o <= 3'h2;
        // Released data bus does not keep its last value
        hwdata_o <= ~hwdata_o;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        hwdata_o <= wd;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rd = hrdata_i;
    endtask

    task automatic wr_word(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, ofs, d, unused);
    endtask

    task automatic rd_word(input logic [7:0] ofs, output logic [31:0] d);
        xfer(1'b0, ofs, ~hwdata_o, d);
    endtask
endmodule // stc_bus_master

//--- sim/tb_top.sv
// Self-checking bench of the timer counter unit, driven over AHB-Lite.
// Assumes the package register map and a 10 MHz system clock.
`timescale 1ns/10ps

module tb_top;
    import stc_pkg::*;

    logic clk, rst_n, ext_tick, hsel, hwrite, hreadyout, hresp, ovf, at_top, at_bottom, cnt_down;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, pins;
    logic [2:0] hsize;
    int mismatches, n_tests;
    int div_tab [1:7] = '{1, 8, 64, 256, 1024, 20, 20};
    logic [7:0] rst_ofs [6] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_CNT_LOW, OFS_CNT_HIGH, OFS_FLAGS,
                                 8'h30};
    logic [1:0] com_tab [3] = '{2'h3, 2'h2, 2'h1};
    logic [1:0] pin_tab [3] = '{2'h3, 2'h0, 2'h3};

    stc_counter_unit stc_counter_unit_i (
        .CLK_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
        .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .EXT_TICK_I(ext_tick),
        .COMPARE_OUTPUT_PIN_O(pins), .OVERFLOW_FLAG_O(ovf), .COUNT_AT_TOP_O(at_top),
        .COUNT_AT_BOTTOM_O(at_bottom), .COUNT_DOWN_O(cnt_down));

    stc_bus_master stc_bus_master_i (
        .clk_i(clk), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
        .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    // ----------------------------------------------------------------
    // Clock, reset and external tick pin
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        ext_tick = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        forever begin
            repeat (10) @(posedge clk);
            ext_tick <= ~ext_tick;
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        stc_bus_master_i.wr_word(ofs, d);
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
        stc_bus_master_i.rd_word(ofs, d);
    endtask

    task automatic wr16(input logic [15:0] v);
        wr(OFS_CNT_HIGH, {24'h0, v[15:8]});
        wr(OFS_CNT_LOW, {24'h0, v[7:0]});
    endtask

    task automatic cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] a,
                       input logic [15:0] cap);
        wr(OFS_CTRL_B, 32'h0);
        wr(OFS_CTRL_A, {24'h0, ca});
        wr(OFS_CMP_A, {16'h0, a});
        wr(OFS_CAPTURE, {16'h0, cap});
        wr16(16'h0000);
        wr(OFS_CTRL_B, {24'h0, cb});
    endtask

    // Cycles between two successive rises of the top indication
    task automatic top_period(output int n);
        n = 0;
        while (at_top !== 1'b0) @(posedge clk);
        while (at_top !== 1'b1) @(posedge clk);
        while (at_top !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        while (at_top !== 1'b1) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic conclude;
        $display("Checks made: %0d, mismatches: %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        conclude();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        int n;
        mismatches = 0;
        n_tests = 0;
        wait (rst_n === 1'b1);
        chk({hresp, ovf, at_top, at_bottom, cnt_down, pins}, 32'h08);
        foreach (rst_ofs[i]) begin
            rd(rst_ofs[i], d);
            chk(d, 32'h0);
        end
        wr(8'h30, 32'h000000FF);
        rd(8'h30, d);
        chk(d, 32'h0);
        wr16(16'h1234);
        wr(OFS_CNT_HIGH, 32'hAB);
        rd(OFS_CNT_HIGH, d);
        chk(d, 32'hAB);
        repeat (20) @(posedge clk);
        rd(OFS_CNT_LOW, d);
        chk(d, 32'h34);
        rd(OFS_CNT_HIGH, d);
        chk(d, 32'h12);
        // Normal mode wrap and overflow
        wr16(16'hFFFF);
        #1;
        chk({at_top, at_bottom}, 32'h2);
        wr(OFS_CTRL_B, {29'h0, CS_DIV1});
        while (at_bottom !== 1'b1) @(posedge clk);
        chk(ovf, 32'h1);
        chk(cnt_down, 32'h0);
        wr(OFS_CTRL_B, 32'h0);
        rd(OFS_FLAGS, d);
        chk(d[0], 32'h1);
        wr(OFS_FLAGS, 32'h1);
        rd(OFS_FLAGS, d);
        chk(d[0], 32'h0);
        // Clear on compare A for every tick source, then clear on capture
        for (int i = 1; i <= 7; i++) begin
            cfg(8'h00, {5'h01, 3'(i)}, 16'h0005, 16'h0009);
            top_period(n);
            chk(n, 6 * div_tab[i]);
        end
        cfg(8'h00, 8'h19, 16'h0005, 16'h0003);
        top_period(n);
        chk(n, 32'd4);
        // Fast PWM with fixed and with capture top, then dual-slope with top at compare A
        cfg(8'h01, 8'h09, 16'h0005, 16'h0009);
        top_period(n);
        chk(n, 32'd256);
        cfg(8'h02, 8'h19, 16'h0002, 16'h0006);
        top_period(n);
        chk(n, 32'd7);
        cfg(8'h03, 8'h11, 16'h0004, 16'h0009);
        top_period(n);
        chk(n, 32'd8);
        @(posedge clk);
        #1;
        chk(cnt_down, 32'h1);
        // Counter write beats the tick of the same cycle
        cfg(8'h00, 8'h09, 16'h0005, 16'h0009);
        repeat (3) @(posedge clk);
        wr(OFS_CNT_HIGH, 32'h0);
        wr(OFS_CNT_LOW, 32'h3);
        @(posedge clk);
        #1;
        chk(at_top, 32'h0);
        @(posedge clk);
        #1;
        chk(at_top, 32'h1);
        // Compare mode change waits for the next match
        cfg(8'h40, 8'h09, 16'h0005, 16'h0009);
        while (pins[0] !== 1'b0) @(posedge clk);
        while (pins[0] !== 1'b1) @(posedge clk);
        wr(OFS_CTRL_A, 32'h80);
        #1;
        chk(pins[0], 32'h1);
        while (at_top !== 1'b1) @(posedge clk);
        #1;
        chk(pins[0], 32'h0);
        // Forced compare actions with the timer stopped
        cfg(8'h00, 8'h08, 16'h0005, 16'h0009);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL_A, {24'h0, com_tab[i], com_tab[i], 4'h0});
            wr(OFS_FORCE, 32'hC0);
            @(posedge clk);
            #1;
            chk(pins, {30'h0, pin_tab[i]});
        end
        conclude();
    end
endmodule // tb_top
